// ### hw/bcr_pkg.sv
// package for the banked processor register state block
// assumes a single 100 MHz core clock and an active high async reset
package bcr_pkg;
  // operating mode encodings held in the status word mode field
  localparam logic [4:0] MODE_USR = 5'h10;
  localparam logic [4:0] MODE_FIQ = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1B;
  localparam logic [4:0] MODE_SYS = 5'h1F;
  // status word field positions
  localparam int SW_N = 31;
  localparam int SW_Z = 30;
  localparam int SW_C = 29;
  localparam int SW_V = 28;
  localparam int SW_IRQ_DIS = 7;
  localparam int SW_FIQ_DIS = 6;
  localparam int SW_STATE = 5;
  localparam int SW_MODE_HI = 4;
  // reset value of the current status word: supervisor, both masks set
  localparam logic [31:0] SW_RESET = 32'h000000D3;
  // register indices of note
  localparam logic [3:0] IDX_SP = 4'hD;
  localparam logic [3:0] IDX_LINK = 4'hE;
  localparam logic [3:0] IDX_PC = 4'hF;
  // physical register slots: 16 shared base, 5 fiq (r8-r12), then
  // 2 each (r13, r14) for fiq, irq, svc, abt, und -> 31 general regs
  localparam int NUM_PHYS = 31;
  localparam logic [4:0] PH_FIQ_LO = 5'h10;
  localparam logic [4:0] PH_BANK_FIQ = 5'h15;
  localparam logic [4:0] PH_BANK_IRQ = 5'h17;
  localparam logic [4:0] PH_BANK_SVC = 5'h19;
  localparam logic [4:0] PH_BANK_ABT = 5'h1B;
  localparam logic [4:0] PH_BANK_UND = 5'h1D;
  // saved status word slot numbers
  localparam logic [2:0] SV_FIQ = 3'h0;
  localparam logic [2:0] SV_IRQ = 3'h1;
  localparam logic [2:0] SV_SVC = 3'h2;
  localparam logic [2:0] SV_ABT = 3'h3;
  localparam logic [2:0] SV_UND = 3'h4;
  localparam logic [2:0] SV_NONE = 3'h7;
  // exception kinds
  typedef enum logic [2:0]
  {
    EXC_RESET = 3'h0,
    EXC_UNDEF = 3'h1,
    EXC_SWI = 3'h2,
    EXC_PABT = 3'h3,
    EXC_DABT = 3'h4,
    EXC_IRQ = 3'h6,
    EXC_FIQ = 3'h7
  } bcr_exc_type;
  // access size on the data bus
  typedef enum logic [1:0]
  {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } bcr_size_type;
  // sequencer state for reset release
  typedef enum logic [1:0]
  {
    ST_RESET = 2'h0,
    ST_RUN = 2'h1
  } bcr_state_type;
endpackage : bcr_pkg

// ### hw/bcr_bank_map.sv
// index translation from architectural register to physical slot
// pure combinational; one instance per register port
`timescale 1ns/1ps
`default_nettype none
module bcr_bank_map
(
  input wire logic [4:0] i_mode,
  input wire logic [3:0] i_idx,
  output logic [4:0] o_phys,
  output logic o_is_pc
);
  // banked r13/r14 base per mode
  logic [4:0] bank_base;
  logic hi_pair;
  logic fiq_lo;
  assign hi_pair = (i_idx == bcr_pkg::IDX_SP) ||
                   (i_idx == bcr_pkg::IDX_LINK);
  assign fiq_lo = (i_mode == bcr_pkg::MODE_FIQ) && i_idx[3] && !hi_pair &&
                  (i_idx != bcr_pkg::IDX_PC);
  assign bank_base =
    (i_mode == bcr_pkg::MODE_FIQ) ? bcr_pkg::PH_BANK_FIQ :
    (i_mode == bcr_pkg::MODE_IRQ) ? bcr_pkg::PH_BANK_IRQ :
    (i_mode == bcr_pkg::MODE_SVC) ? bcr_pkg::PH_BANK_SVC :
    (i_mode == bcr_pkg::MODE_ABT) ? bcr_pkg::PH_BANK_ABT :
    (i_mode == bcr_pkg::MODE_UND) ? bcr_pkg::PH_BANK_UND : 5'h00;
  assign o_is_pc = (i_idx == bcr_pkg::IDX_PC);
  // user and system share the base r13/r14
  assign o_phys =
    fiq_lo ? 5'(bcr_pkg::PH_FIQ_LO + 5'(i_idx - 4'h8)) :
    (hi_pair && bank_base != 5'h00) ?
      5'(bank_base + {4'h0, i_idx[0]}) :
    {1'b0, i_idx};
endmodule : bcr_bank_map
`default_nettype wire

// ### hw/bcr_core_regs.sv
// banked register state: general regs, program counter, status words,
// state switching, exception entry and data bus byte lane steering
// assumes the pipeline drives one request of each kind per cycle
`timescale 1ns/1ps
`default_nettype none
module bcr_core_regs
#(
  parameter int DATA_W = 32,
  parameter logic [31:0] VECTOR_BASE = 32'h00000000
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  // read ports, architectural index
  input wire logic [3:0] i_ra_idx,
  input wire logic [3:0] i_rb_idx,
  // write port
  input wire logic i_wr_en,
  input wire logic [3:0] i_wr_idx,
  input wire logic [31:0] i_wr_data,
  // status word write by privileged software
  input wire logic i_sw_wr,
  input wire logic [31:0] i_sw_data,
  input wire logic i_flags_wr,
  input wire logic [3:0] i_flags,
  // program counter advance and branches
  input wire logic i_pc_step,
  input wire logic i_branch,
  input wire logic [31:0] i_branch_tgt,
  input wire logic i_branch_link,
  input wire logic i_bx,
  input wire logic [31:0] i_bx_opnd,
  // exception entry and return
  input wire logic i_exc,
  input wire logic [2:0] i_exc_kind,
  input wire logic i_exc_ret,
  input wire logic [31:0] i_ret_addr,
  // endian select and data bus request
  input wire logic i_big_endian,
  input wire logic i_mem_req,
  input wire logic [31:0] i_mem_addr,
  input wire logic [1:0] i_mem_size,
  input wire logic [31:0] i_st_data,
  input wire logic [31:0] i_bus_rdata,
  // outputs
  output logic [31:0] o_ra_data,
  output logic [31:0] o_rb_data,
  output logic [31:0] o_program_counter,
  output logic [31:0] o_fetch_addr,
  output logic o_half_sel,
  output logic [31:0] o_current_status_word,
  output logic [31:0] o_saved_status_word,
  output logic o_compact,
  output logic o_irq_off,
  output logic o_fiq_off,
  output logic [31:0] o_bus_wdata,
  output logic [3:0] o_bus_lanes,
  output logic [31:0] o_ld_data,
  output logic o_align_err
);
  initial
  begin
    if (DATA_W != 32)
      $error("bcr_core_regs: only 32-bit data supported");
  end

  // physical storage: 31 general, pc, current and five saved words
  logic [31:0] gpr_ff [bcr_pkg::NUM_PHYS];
  logic [31:0] pc_ff;
  logic [31:0] cur_ff;
  logic [31:0] sav_ff [5];
  logic [31:0] ra_ff, rb_ff, bw_ff, ld_ff;
  logic [3:0] lanes_ff;
  logic aerr_ff;
  bcr_pkg::bcr_state_type st_ff;
  logic [31:0] sav_shadow_ff; // saved word of the current mode
  logic half_ff; // halfword select of the current pc

  // mode and state taken from the current status word
  logic [4:0] mode;
  logic compact;
  assign mode = cur_ff[bcr_pkg::SW_MODE_HI:0];
  assign compact = cur_ff[bcr_pkg::SW_STATE];

  // saved word slot for a mode; user and system have none
  function automatic logic [2:0] sv_slot(input logic [4:0] m);
    logic [2:0] s;
    s = bcr_pkg::SV_NONE;
    if (m == bcr_pkg::MODE_FIQ)
      s = bcr_pkg::SV_FIQ;
    else if (m == bcr_pkg::MODE_IRQ)
      s = bcr_pkg::SV_IRQ;
    else if (m == bcr_pkg::MODE_SVC)
      s = bcr_pkg::SV_SVC;
    else if (m == bcr_pkg::MODE_ABT)
      s = bcr_pkg::SV_ABT;
    else if (m == bcr_pkg::MODE_UND)
      s = bcr_pkg::SV_UND;
    return s;
  endfunction : sv_slot

  // index translation, one mapper per port, no extra cycle
  logic [4:0] ra_ph, rb_ph, wr_ph, lk_ph, xlk_ph;
  logic ra_pc, rb_pc, wr_pc;
  // index passes through unchanged, so compact state reaches r0-r15 by index
  logic [3:0] ra_i, rb_i;
  assign ra_i = ra_idx_fix(i_ra_idx);
  assign rb_i = ra_idx_fix(i_rb_idx);
  function automatic logic [3:0] ra_idx_fix(input logic [3:0] x);
    return x; // hi-register moves still reach r8-r12
  endfunction : ra_idx_fix
  bcr_bank_map u_map_a (.i_mode(mode), .i_idx(ra_i), .o_phys(ra_ph),
    .o_is_pc(ra_pc));
  bcr_bank_map u_map_b (.i_mode(mode), .i_idx(rb_i), .o_phys(rb_ph),
    .o_is_pc(rb_pc));
  bcr_bank_map u_map_w (.i_mode(mode), .i_idx(i_wr_idx), .o_phys(wr_ph),
    .o_is_pc(wr_pc));
  bcr_bank_map u_map_l (.i_mode(mode), .i_idx(bcr_pkg::IDX_LINK),
    .o_phys(lk_ph), .o_is_pc());

  // exception target mode and vector
  logic [4:0] xmode;
  logic [31:0] xvec;
  assign xmode =
    (i_exc_kind == bcr_pkg::EXC_FIQ) ? bcr_pkg::MODE_FIQ :
    (i_exc_kind == bcr_pkg::EXC_IRQ) ? bcr_pkg::MODE_IRQ :
    (i_exc_kind == bcr_pkg::EXC_UNDEF) ? bcr_pkg::MODE_UND :
    (i_exc_kind == bcr_pkg::EXC_PABT) ? bcr_pkg::MODE_ABT :
    (i_exc_kind == bcr_pkg::EXC_DABT) ? bcr_pkg::MODE_ABT :
    bcr_pkg::MODE_SVC;
  assign xvec = VECTOR_BASE + {27'h0, i_exc_kind, 2'h0};
  bcr_bank_map u_map_x (.i_mode(xmode), .i_idx(bcr_pkg::IDX_LINK),
    .o_phys(xlk_ph), .o_is_pc());
  // masked interrupt kinds are refused
  logic exc_ok;
  assign exc_ok = i_exc && !(
    (i_exc_kind == bcr_pkg::EXC_IRQ && cur_ff[bcr_pkg::SW_IRQ_DIS]) ||
    (i_exc_kind == bcr_pkg::EXC_FIQ && cur_ff[bcr_pkg::SW_FIQ_DIS]));

  // program counter read value with low bits forced to zero
  logic [31:0] pc_rd;
  assign pc_rd = compact ? {pc_ff[31:1], 1'b0}
                         : {pc_ff[31:2], 2'b00};
  logic [2:0] cur_slot;
  assign cur_slot = sv_slot(mode);
  logic [31:0] pc_step;
  assign pc_step = compact ? 32'h00000002 : 32'h00000004;

  // next state of the current status word
  logic [31:0] nxt_cur;
  always_comb
  begin
    nxt_cur = cur_ff;
    if (exc_ok)
    begin
      // enter mode, wide state, mask normal interrupt (and fast for fiq)
      nxt_cur[bcr_pkg::SW_MODE_HI:0] = xmode;
      nxt_cur[bcr_pkg::SW_STATE] = 1'b0;
      nxt_cur[bcr_pkg::SW_IRQ_DIS] = 1'b1;
      if (i_exc_kind == bcr_pkg::EXC_FIQ)
        nxt_cur[bcr_pkg::SW_FIQ_DIS] = 1'b1;
    end
    else if (i_exc_ret && cur_slot != bcr_pkg::SV_NONE)
      nxt_cur = sav_ff[cur_slot]; // restores state bit too
    else if (i_bx)
      nxt_cur[bcr_pkg::SW_STATE] = i_bx_opnd[0];
    else if (i_sw_wr && mode != bcr_pkg::MODE_USR)
      // software keeps the state bit; mode and masks change
      nxt_cur = {i_sw_data[31:6], cur_ff[5], i_sw_data[4:0]};
    else if (i_flags_wr)
      nxt_cur[31:28] = i_flags;
  end

  // next program counter
  logic [31:0] nxt_pc;
  assign nxt_pc =
    exc_ok ? xvec :
    i_exc_ret ? i_ret_addr :
    i_bx ? {i_bx_opnd[31:1], 1'b0} :
    i_branch ? i_branch_tgt :
    (i_wr_en && wr_pc) ? i_wr_data :
    i_pc_step ? pc_rd + pc_step : pc_ff;

  // status word and program counter registers
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cur_ff <= bcr_pkg::SW_RESET; // reset acts as an exception
      pc_ff <= 32'h00000000;
      st_ff <= bcr_pkg::ST_RESET;
    end
    else
    begin
      cur_ff <= nxt_cur;
      pc_ff <= (st_ff == bcr_pkg::ST_RESET) ? VECTOR_BASE : nxt_pc;
      st_ff <= bcr_pkg::ST_RUN;
    end
  end

  // saved status words, written on exception entry
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < 5; k++)
        sav_ff[k] <= 32'h00000000;
    end
    else if (exc_ok && sv_slot(xmode) != bcr_pkg::SV_NONE)
      sav_ff[sv_slot(xmode)] <= cur_ff;
  end

  // general registers: exception link, branch link, then normal write
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < bcr_pkg::NUM_PHYS; k++)
        gpr_ff[k] <= 32'h00000000;
    end
    else if (exc_ok)
      gpr_ff[xlk_ph] <= pc_rd;
    else if (i_branch && i_branch_link)
      gpr_ff[lk_ph] <= pc_rd + pc_step;
    else if (i_wr_en && !wr_pc)
      gpr_ff[wr_ph] <= i_wr_data;
  end

  // byte lanes and endian steering
  logic [1:0] bsel;
  logic [3:0] lanes;
  logic mis;
  logic [31:0] wdat, ldat;
  logic [7:0] rbyte;
  logic [15:0] rhalf;
  assign bsel = i_big_endian ? ~i_mem_addr[1:0] : i_mem_addr[1:0];
  assign mis = (i_mem_size == bcr_pkg::SZ_WORD && i_mem_addr[1:0] != 2'h0) ||
               (i_mem_size == bcr_pkg::SZ_HALF && i_mem_addr[0]);
  assign lanes =
    (i_mem_size == bcr_pkg::SZ_WORD) ? 4'hF :
    (i_mem_size == bcr_pkg::SZ_HALF) ? (bsel[1] ? 4'hC : 4'h3) :
    4'(4'h1 << bsel);
  assign wdat = (i_mem_size == bcr_pkg::SZ_WORD) ? i_st_data :
                (i_mem_size == bcr_pkg::SZ_HALF) ? {2{i_st_data[15:0]}} :
                {4{i_st_data[7:0]}};
  assign rbyte = i_bus_rdata[{bsel, 3'h0} +: 8];
  assign rhalf = bsel[1] ? i_bus_rdata[31:16] : i_bus_rdata[15:0];
  assign ldat = (i_mem_size == bcr_pkg::SZ_WORD) ? i_bus_rdata :
                (i_mem_size == bcr_pkg::SZ_HALF) ? {16'h0, rhalf} :
                {24'h0, rbyte};

  // registered outputs
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ra_ff <= 32'h00000000;
      rb_ff <= 32'h00000000;
      bw_ff <= 32'h00000000;
      ld_ff <= 32'h00000000;
      lanes_ff <= 4'h0;
      aerr_ff <= 1'b0;
    end
    else
    begin
      ra_ff <= ra_pc ? pc_rd : gpr_ff[ra_ph];
      rb_ff <= rb_pc ? pc_rd : gpr_ff[rb_ph];
      bw_ff <= wdat;
      ld_ff <= ldat;
      lanes_ff <= (i_mem_req && !mis) ? lanes : 4'h0;
      aerr_ff <= i_mem_req && mis;
    end
  end

  assign o_ra_data = ra_ff;
  assign o_rb_data = rb_ff;
  assign o_program_counter = pc_ff;
  assign o_fetch_addr = pc_ff;
  assign o_half_sel = half_ff;
  assign o_current_status_word = cur_ff;
  assign o_saved_status_word = sav_shadow_ff;
  assign o_compact = cur_ff[bcr_pkg::SW_STATE];
  assign o_irq_off = cur_ff[bcr_pkg::SW_IRQ_DIS];
  assign o_fiq_off = cur_ff[bcr_pkg::SW_FIQ_DIS];
  assign o_bus_wdata = bw_ff;
  assign o_bus_lanes = lanes_ff;
  assign o_ld_data = ld_ff;
  assign o_align_err = aerr_ff;

  // saved word of the coming mode and halfword select, registered;
  // on exception entry the word being saved shows in the same cycle
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sav_shadow_ff <= 32'h00000000;
      half_ff <= 1'b0;
    end
    else
    begin
      sav_shadow_ff <= (sv_slot(nxt_cur[4:0]) == bcr_pkg::SV_NONE) ?
        32'h00000000 : exc_ok ? cur_ff : sav_ff[sv_slot(nxt_cur[4:0])];
      half_ff <= nxt_cur[bcr_pkg::SW_STATE] &
        ((st_ff == bcr_pkg::ST_RESET) ? VECTOR_BASE[1] : nxt_pc[1]);
    end
  end

  // checks
  a_bx_state: assert property (@(posedge i_clk) disable iff (i_rst)
    i_bx && !i_exc && !i_exc_ret |=> o_compact == $past(i_bx_opnd[0]))
    else $error("branch exchange state wrong");
  a_exc_wide: assert property (@(posedge i_clk) disable iff (i_rst)
    exc_ok |=> !o_compact && o_current_status_word[4:0] == $past(xmode))
    else $error("exception entry state wrong");
  a_exc_vec: assert property (@(posedge i_clk) disable iff (i_rst)
    exc_ok && st_ff == bcr_pkg::ST_RUN |=> o_program_counter == $past(xvec))
    else $error("exception vector wrong");
  a_mask_irq: assert property (@(posedge i_clk) disable iff (i_rst)
    i_exc && i_exc_kind == bcr_pkg::EXC_IRQ && o_irq_off && !i_exc_ret &&
    !i_bx && !i_sw_wr && !i_flags_wr
    |=> o_current_status_word == $past(o_current_status_word))
    else $error("masked interrupt taken");
  a_pc_align: assert property (@(posedge i_clk) disable iff (i_rst)
    o_ra_data[0] == 1'b0 || !$past(ra_pc))
    else $error("pc low bit not zero");
  a_big_lane: assert property (@(posedge i_clk) disable iff (i_rst)
    i_mem_req && i_big_endian && i_mem_size == bcr_pkg::SZ_BYTE &&
    i_mem_addr[1:0] == 2'h0 |=> o_bus_lanes == 4'h8)
    else $error("big endian byte lane wrong");
  a_lit_lane: assert property (@(posedge i_clk) disable iff (i_rst)
    i_mem_req && !i_big_endian && i_mem_size == bcr_pkg::SZ_BYTE &&
    i_mem_addr[1:0] == 2'h0 |=> o_bus_lanes == 4'h1)
    else $error("little endian byte lane wrong");
  a_align_err: assert property (@(posedge i_clk)
    disable iff (i_rst)
    i_mem_req && i_mem_size == bcr_pkg::SZ_WORD && i_mem_addr[1:0] != 2'h0
    |=> o_align_err && o_bus_lanes == 4'h0)
    else $error("misaligned word accepted");
  a_ret_state: assert property (@(posedge i_clk) disable iff (i_rst)
    i_exc_ret && !i_exc && cur_slot != bcr_pkg::SV_NONE
    |=> o_compact == $past(sav_ff[cur_slot][5]))
    else $error("return state not restored");
endmodule : bcr_core_regs
`default_nettype wire

// ### bench/bcr_mem_model.sv
// word memory on the far side of the data bus, four words deep
// assumes the bench marks each request as a load or a store
`timescale 1ns/1ps
`default_nettype none
module bcr_mem_model
(
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [3:0] i_lanes,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata
);
  logic [31:0] mem_ff [4]; // storage, word addressed
  logic [1:0] addr_ff; // word of the pending store
  logic we_ff; // store waiting for its lane enables
  logic [31:0] last_ff; // last word handed out
  initial
  begin
    foreach (mem_ff[i]) mem_ff[i] = 32'h8899AABB;
    last_ff = 32'h0;
    we_ff = 1'b0;
  end
  // released bus shows the inverse of the last word, never stale data
  assign o_rdata = i_req ? mem_ff[i_addr[3:2]] : ~last_ff;
  // store lands one edge after the request, on the enabled lanes only
  always @(posedge i_clk)
  begin
    if (i_req)
    begin
      addr_ff <= i_addr[3:2];
      last_ff <= o_rdata;
    end
    we_ff <= i_req & i_we;
    if (we_ff)
      for (int b = 0; b < 4; b++)
        if (i_lanes[b])
          mem_ff[addr_ff][b*8 +: 8] <= i_wdata[b*8 +: 8];
  end
endmodule : bcr_mem_model
`default_nettype wire

// ### bench/tb_bcr_core_regs.sv
// self-checking bench for the banked register state block
// assumes one request of each kind per cycle, outputs one cycle later
`timescale 1ns/1ps
`default_nettype none
module tb_bcr_core_regs;
  localparam logic [31:0] VB = 32'h00001000; // vector base under test
  localparam int O_WR = 0;
  localparam int O_SW = 1;
  localparam int O_FL = 2;
  localparam int O_STEP = 3;
  localparam int O_BR = 4;
  localparam int O_BX = 5;
  localparam int O_EXC = 6;
  localparam int O_RET = 7;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_ra_idx = 4'h0, i_rb_idx = 4'h0, i_wr_idx = 4'h0;
  logic [3:0] i_flags = 4'h0;
  logic i_wr_en = 1'b0, i_sw_wr = 1'b0, i_flags_wr = 1'b0;
  logic i_pc_step = 1'b0, i_branch = 1'b0, i_branch_link = 1'b0;
  logic i_bx = 1'b0, i_exc = 1'b0, i_exc_ret = 1'b0;
  logic i_big_endian = 1'b1, i_mem_req = 1'b0, mem_we = 1'b0;
  logic [2:0] i_exc_kind = 3'h0;
  logic [1:0] i_mem_size = 2'h0;
  logic [31:0] i_wr_data = 32'h0, i_sw_data = 32'h0, i_branch_tgt = 32'h0;
  logic [31:0] i_bx_opnd = 32'h0, i_ret_addr = 32'h0, i_mem_addr = 32'h0;
  logic [31:0] i_st_data = 32'h0, i_bus_rdata;
  logic [31:0] o_ra_data, o_rb_data, o_program_counter, o_fetch_addr;
  logic [31:0] o_current_status_word, o_saved_status_word;
  logic [31:0] o_bus_wdata, o_ld_data;
  logic [3:0] o_bus_lanes;
  logic o_half_sel, o_compact, o_irq_off, o_fiq_off, o_align_err;
  logic [4:0] md [6]; // privileged modes to visit
  int fail_count = 0;
  int cmp_count = 0;
  bcr_core_regs #(.VECTOR_BASE(VB)) bcr_core_regs_i
  (
    .i_clk(i_clk), .i_rst(i_rst), .i_ra_idx(i_ra_idx), .i_rb_idx(i_rb_idx),
    .i_wr_en(i_wr_en), .i_wr_idx(i_wr_idx), .i_wr_data(i_wr_data),
    .i_sw_wr(i_sw_wr), .i_sw_data(i_sw_data), .i_flags_wr(i_flags_wr),
    .i_flags(i_flags), .i_pc_step(i_pc_step), .i_branch(i_branch),
    .i_branch_tgt(i_branch_tgt), .i_branch_link(i_branch_link),
    .i_bx(i_bx), .i_bx_opnd(i_bx_opnd), .i_exc(i_exc),
    .i_exc_kind(i_exc_kind), .i_exc_ret(i_exc_ret),
    .i_ret_addr(i_ret_addr), .i_big_endian(i_big_endian),
    .i_mem_req(i_mem_req), .i_mem_addr(i_mem_addr),
    .i_mem_size(i_mem_size), .i_st_data(i_st_data),
    .i_bus_rdata(i_bus_rdata), .o_ra_data(o_ra_data),
    .o_rb_data(o_rb_data), .o_program_counter(o_program_counter),
    .o_fetch_addr(o_fetch_addr), .o_half_sel(o_half_sel),
    .o_current_status_word(o_current_status_word),
    .o_saved_status_word(o_saved_status_word), .o_compact(o_compact),
    .o_irq_off(o_irq_off), .o_fiq_off(o_fiq_off),
    .o_bus_wdata(o_bus_wdata), .o_bus_lanes(o_bus_lanes),
    .o_ld_data(o_ld_data), .o_align_err(o_align_err)
  );
  bcr_mem_model bcr_mem_model_i
  (
    .i_clk(i_clk), .i_req(i_mem_req), .i_we(mem_we), .i_addr(i_mem_addr),
    .i_lanes(o_bus_lanes), .i_wdata(o_bus_wdata), .o_rdata(i_bus_rdata)
  );
  // free running 100 MHz clock
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end
  // compare one value and count it
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // counts, verdict and end of run
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // one pulse request of kind k, outputs settled on return
  task op(input int k, input logic [31:0] a, input logic [31:0] b);
    @(posedge i_clk);
    i_wr_idx <= a[3:0];
    i_wr_data <= b;
    i_sw_data <= a;
    i_flags <= a[3:0];
    i_branch_tgt <= a;
    i_branch_link <= b[0];
    i_bx_opnd <= a;
    i_exc_kind <= a[2:0];
    i_ret_addr <= a;
    case (k)
      O_WR: i_wr_en <= 1'b1;
      O_SW: i_sw_wr <= 1'b1;
      O_FL: i_flags_wr <= 1'b1;
      O_STEP: i_pc_step <= 1'b1;
      O_BR: i_branch <= 1'b1;
      O_BX: i_bx <= 1'b1;
      O_EXC: i_exc <= 1'b1;
      default: i_exc_ret <= 1'b1;
    endcase
    @(posedge i_clk);
    {i_wr_en, i_sw_wr, i_flags_wr, i_pc_step} <= 4'h0;
    {i_branch, i_branch_link, i_bx, i_exc, i_exc_ret} <= 5'h0;
    #1;
  endtask : op
  // read one index on both read ports
  task rd(input logic [3:0] idx, input logic [31:0] exp);
    @(posedge i_clk);
    i_ra_idx <= idx;
    i_rb_idx <= idx;
    @(posedge i_clk);
    #1;
    check("read port a", o_ra_data, exp);
    check("read port b", o_rb_data, exp);
  endtask : rd
  // one data bus access with expected lanes, load data and error
  task mem(input logic [31:0] a, input logic [1:0] sz, input logic we,
           input logic [31:0] st, input logic [3:0] ln,
           input logic [31:0] ld, input logic er);
    @(posedge i_clk);
    i_mem_req <= 1'b1;
    i_mem_addr <= a;
    i_mem_size <= sz;
    i_st_data <= st;
    mem_we <= we;
    @(posedge i_clk);
    i_mem_req <= 1'b0;
    mem_we <= 1'b0;
    #1;
    check("lanes", {28'h0, o_bus_lanes}, {28'h0, ln});
    check("align", {31'h0, o_align_err}, {31'h0, er});
    if (!we && !er)
      check("load", o_ld_data, ld);
  endtask : mem
  // hang guard
  initial
  begin
    repeat (5000) @(posedge i_clk);
    fail_count++;
    print_verdict();
  end
  // main sequence
  initial
  begin
    md = '{5'h11, 5'h12, 5'h13, 5'h17, 5'h1B, 5'h1F};
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    check("status", o_current_status_word, 32'h000000D3);
    check("pc", o_program_counter, VB);
    op(O_WR, 32'hD, 32'h5A5A0013);
    op(O_WR, 32'h0, 32'h000000C0);
    op(O_WR, 32'h8, 32'h00000808);
    op(O_BR, 32'h300, 32'h1);
    check("pc", o_program_counter, 32'h300);
    rd(4'hE, VB + 32'h4);
    op(O_SW, 32'hD1, 32'h0);
    rd(4'h8, 32'h0);
    op(O_WR, 32'h8, 32'hF1F1F1F1);
    rd(4'hD, 32'h0);
    rd(4'h0, 32'hC0);
    op(O_SW, 32'hD3, 32'h0);
    rd(4'h8, 32'h808);
    rd(4'hD, 32'h5A5A0013);
    for (int i = 0; i < 6; i++)
    begin
      op(O_SW, {24'h0, 3'h6, md[i]}, 32'h0);
      check("mode", o_current_status_word, {24'h0, 3'h6, md[i]});
    end
    op(O_SW, 32'hD0, 32'h0);
    check("user", o_current_status_word, 32'hD0);
    op(O_SW, 32'hD3, 32'h0);
    check("user lock", o_current_status_word, 32'hD0);
    op(O_EXC, 32'h0, 32'h0);
    check("mode", {27'h0, o_current_status_word[4:0]}, 32'h13);
    check("pc", o_program_counter, VB);
    check("saved", o_saved_status_word, 32'hD0);
    rd(4'hE, 32'h300);
    op(O_SW, 32'h13, 32'h0);
    op(O_FL, 32'hA, 32'h0);
    check("status", o_current_status_word, 32'hA0000013);
    check("masks", {30'h0, o_irq_off, o_fiq_off}, 32'h0);
    op(O_BX, 32'h103, 32'h0);
    check("compact", {31'h0, o_compact}, 32'h1);
    check("pc", o_program_counter, 32'h102);
    check("half", {31'h0, o_half_sel}, 32'h1);
    check("status", o_current_status_word, 32'hA0000033);
    rd(4'h0, 32'hC0);
    rd(4'hF, 32'h102);
    op(O_STEP, 32'h0, 32'h0);
    check("fetch", o_fetch_addr, 32'h104);
    check("half", {31'h0, o_half_sel}, 32'h0);
    op(O_EXC, 32'h6, 32'h0);
    check("status", o_current_status_word, 32'hA0000092);
    check("pc", o_program_counter, VB + 32'h18);
    check("saved", o_saved_status_word, 32'hA0000033);
    rd(4'hE, 32'h104);
    rd(4'hD, 32'h0);
    op(O_EXC, 32'h6, 32'h0);
    check("masked", o_program_counter, VB + 32'h18);
    op(O_STEP, 32'h0, 32'h0);
    check("fetch", o_fetch_addr, VB + 32'h1C);
    op(O_RET, 32'h104, 32'h0);
    check("status", o_current_status_word, 32'hA0000033);
    check("pc", o_program_counter, 32'h104);
    rd(4'hD, 32'h5A5A0013);
    rd(4'hE, 32'h300);
    op(O_BX, 32'h200, 32'h0);
    check("compact", {31'h0, o_compact}, 32'h0);
    check("pc", o_program_counter, 32'h200);
    mem(32'h0, 2'h0, 1'b0, 32'h0, 4'h8, 32'h88, 1'b0);
    mem(32'h2, 2'h1, 1'b0, 32'h0, 4'h3, 32'hAABB, 1'b0);
    mem(32'h5, 2'h0, 1'b1, 32'h5C, 4'h4, 32'h0, 1'b0);
    check("wdata", o_bus_wdata, 32'h5C5C5C5C);
    mem(32'h4, 2'h2, 1'b0, 32'h0, 4'hF, 32'h885CAABB, 1'b0);
    mem(32'h2, 2'h2, 1'b1, 32'h0, 4'h0, 32'h0, 1'b1);
    mem(32'h3, 2'h1, 1'b0, 32'h0, 4'h0, 32'h0, 1'b1);
    @(posedge i_clk);
    i_big_endian <= 1'b0;
    mem(32'h0, 2'h0, 1'b0, 32'h0, 4'h1, 32'hBB, 1'b0);
    mem(32'h2, 2'h1, 1'b0, 32'h0, 4'hC, 32'h8899, 1'b0);
    mem(32'h6, 2'h0, 1'b1, 32'h77, 4'h4, 32'h0, 1'b0);
    mem(32'h5, 2'h0, 1'b0, 32'h0, 4'h2, 32'hAA, 1'b0);
    @(posedge i_clk);
    i_big_endian <= 1'b1;
    mem(32'h5, 2'h0, 1'b0, 32'h0, 4'h4, 32'h77, 1'b0);
    print_verdict();
  end
endmodule : tb_bcr_core_regs
`default_nettype wire
